/* tb/sle_ctl_model.sv */
// controller model: logs each alarm word and its arrival cycle
// assumes alarm is a same-clock register whose valid stands one cycle
`timescale 1ns/1ps
module sle_ctl_model (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              resetn,
   // alarm from the block
   input  sle_pkg::sle_alarm_type alarm
);
   logic [13:0] word_q[$];
   int          stamp_q[$];
   int          cyc;

   // one log entry per valid cycle, nothing filtered or masked
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cyc = 0;
      end else begin
         if (alarm.valid === 1'b1) begin
            word_q.push_back({alarm.chan_scope, alarm.chan, alarm.code});
            stamp_q.push_back(cyc);
         end
         cyc = cyc + 1;
      end
   end
endmodule : sle_ctl_model

/* tb/tb_top.sv */
// bench: led rows, alarm codes, reset and corner cases
// assumes sle_cfg.svh on the include path and a 100 MHz clock
`timescale 1ns/1ps
`include "sle_cfg.svh"
module tb_top;
   typedef struct packed {
      logic [6:0]             m;
      logic [23:0]            c;
      sle_pkg::sle_dmode_type dm;
      logic [7:0]             st;
      logic [7:0]             ft;
      logic [7:0]             fl;
      logic                   alt;
   } sle_row_type;

   localparam int BLINK = 4;
   logic                     clock;
   logic                     resetn     = 1'b0;
   sle_pkg::sle_mstate_type  mstate     = '0;
   sle_pkg::sle_chstate_type chstate    = '0;
   logic [`SLE_NUM_MEV-1:0]  mod_evt    = '0;
   logic [`SLE_NUM_CH*4-1:0] ch_evt     = '0;
   logic                     diag_clear = 1'b0;
   logic                     diag_green_ff;
   logic                     diag_red_ff;
   logic                     load_supply_indicator_ff;
   logic [7:0]               chan_status_ff;
   logic [7:0]               chan_fault_ff;
   sle_pkg::sle_alarm_type   alarm_ff;
   int                       n_mismatch = 0;
   int                       cmp_count  = 0;
   int                       mcode[27]  = '{5, 9, 16, 17, 25, 31, 64, 65, 66, 67, 68, 69, 70, 71, 73, 74, 75,
                                            76, 77, 78, 256, 259, 283, 781, 786, 801, 802};
   int                       ccode[4]   = '{261, 262, 779, 785};
   sle_row_type              rows[10]   = '{
      '{7'h30, 24'ha50000, sle_pkg::DIAG_DARK, 8'ha5, 8'h00, 8'h00, 1'b0},
      '{7'h50, 24'h3cf000, sle_pkg::DIAG_STEADY, 8'h0c, 8'hf0, 8'h00, 1'b0},
      '{7'h60, 24'h000000, sle_pkg::DIAG_FLASH, 8'h00, 8'h00, 8'h00, 1'b0},
      '{7'h78, 24'h000000, sle_pkg::DIAG_FLASH, 8'h00, 8'h00, 8'h00, 1'b0},
      '{7'h70, 24'h020081, sle_pkg::DIAG_FLASH, 8'h02, 8'h00, 8'h81, 1'b1},
      '{7'h74, 24'h000000, sle_pkg::DIAG_FLASH, 8'h00, 8'h00, 8'h00, 1'b0},
      '{7'h72, 24'hff0000, sle_pkg::DIAG_FLASH, 8'h00, 8'hff, 8'h00, 1'b0},
      '{7'h71, 24'hff0f00, sle_pkg::DIAG_FLASH, 8'h00, 8'h00, 8'hff, 1'b0},
      '{7'h73, 24'hff0000, sle_pkg::DIAG_FLASH, 8'h00, 8'hff, 8'h00, 1'b0},
      '{7'h02, 24'h000000, sle_pkg::DIAG_DARK, 8'h00, 8'hff, 8'h00, 1'b0}
   };

   sle_status_led #(.BLINK_CYCLES(BLINK)) sle_status_led_i (
      .clock(clock), .resetn(resetn), .mstate(mstate), .chstate(chstate), .mod_evt(mod_evt),
      .ch_evt(ch_evt), .diag_clear(diag_clear), .diag_green_ff(diag_green_ff), .diag_red_ff(diag_red_ff),
      .load_supply_indicator_ff(load_supply_indicator_ff), .chan_status_ff(chan_status_ff),
      .chan_fault_ff(chan_fault_ff), .alarm_ff(alarm_ff));
   sle_ctl_model sle_ctl_model_i (.clock(clock), .resetn(resetn), .alarm(alarm_ff));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic tick();
      @(posedge clock);
      #1;
   endtask : tick

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   // holds one state, watches one blink period plus two cycles
   task automatic run_row(input sle_row_type r);
      logic ror;
      logic r_all;
      ror = 1'b0;
      r_all = 1'b1;
      mstate = r.m;
      chstate = r.c;
      repeat (2) tick();
      repeat (2 * BLINK + 2) begin
         chk(load_supply_indicator_ff, r.m[5], "supply");
         chk(diag_green_ff, r.dm == sle_pkg::DIAG_STEADY, "green");
         if (r.dm != sle_pkg::DIAG_FLASH) chk(diag_red_ff, 1'b0, "red");
         chk(chan_status_ff & ~r.fl, r.st & ~r.fl, "status");
         chk(chan_fault_ff & ~r.fl, r.ft & ~r.fl, "fault");
         chk(chan_status_ff & r.fl, {8{diag_red_ff}} & r.fl, "status phase");
         chk(chan_fault_ff & r.fl, r.alt ? ~chan_status_ff & r.fl : 8'h00, "fault phase");
         ror = ror | diag_red_ff;
         r_all = r_all & diag_red_ff;
         tick();
      end
      if (r.dm == sle_pkg::DIAG_FLASH) chk({ror, r_all}, 2'b10, "flash");
   endtask : run_row

   task automatic fire(input int i);
      if (i < 27) mod_evt[i] = 1'b1;
      else ch_evt[i-27] = 1'b1;
      tick();
      mod_evt = '0;
      ch_evt = '0;
   endtask : fire

   function automatic logic [13:0] exp_word(input int i);
      if (i < 27) return {4'h0, 10'(mcode[i])};
      return {1'b1, 3'((i - 27) / 4), 10'(ccode[(i - 27) % 4])};
   endfunction : exp_word

   task automatic take(input int i, input int p);
      chk(sle_ctl_model_i.word_q.size() > 0, 1'b1, "alarm count");
      if (sle_ctl_model_i.word_q.size() > 0) begin
         chk(sle_ctl_model_i.word_q.pop_front(), exp_word(i), "alarm word");
         chk(sle_ctl_model_i.stamp_q.pop_front(), p + 2, "alarm time");
      end
   endtask : take

   initial begin
      #50000;
      n_mismatch++;
      $display("Error at %0t: watchdog expired", $time);
      give_verdict();
   end

   initial begin
      int p;
      repeat (2) @(posedge clock);
      #1;
      resetn = 1'b1;
      chk({diag_green_ff, diag_red_ff, load_supply_indicator_ff, chan_status_ff, chan_fault_ff, alarm_ff.valid}, 0,
          "reset");
      foreach (rows[i]) run_row(rows[i]);
      // every event alone, one alarm each
      mstate = 7'h70;
      chstate = '0;
      tick();
      for (int i = 0; i < 59; i++) begin
         p = sle_ctl_model_i.cyc;
         fire(i);
         repeat (4) tick();
         take(i, p);
      end
      run_row(sle_row_type'{7'h70, 24'h0, sle_pkg::DIAG_FLASH, 8'h00, 8'h00, 8'h00, 1'b0});
      diag_clear = 1'b1;
      tick();
      diag_clear = 1'b0;
      run_row(sle_row_type'{7'h70, 24'h0, sle_pkg::DIAG_STEADY, 8'h00, 8'h00, 8'h00, 1'b0});
      // three events in one cycle, served lowest index first
      p = sle_ctl_model_i.cyc;
      mod_evt = 27'h4000001;
      ch_evt = 32'h00000010;
      tick();
      mod_evt = '0;
      ch_evt = '0;
      repeat (5) tick();
      take(0, p);
      take(26, p + 1);
      take(31, p + 2);
      // reset in mid-run
      chstate = 24'hff0000;
      repeat (3) tick();
      resetn = 1'b0;
      #1;
      chk({diag_green_ff, diag_red_ff, load_supply_indicator_ff, chan_status_ff, chan_fault_ff, alarm_ff.valid}, 0,
          "mid reset");
      tick();
      resetn = 1'b1;
      run_row(sle_row_type'{7'h70, 24'hff0000, sle_pkg::DIAG_STEADY, 8'hff, 8'h00, 8'h00, 1'b0});
      give_verdict();
   end
endmodule : tb_top

/* verilog/sle_alarm_enc.sv */
// alarm encoder: holds pending events, emits one coded alarm a cycle
// assumes event inputs are same-clock one-cycle pulses
`timescale 1ns/1ps
`include "sle_cfg.svh"
module sle_alarm_enc (
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         resetn,
   // events
   input  wire logic [`SLE_NUM_MEV-1:0]      mod_evt,
   input  wire logic [`SLE_NUM_CH*4-1:0]     ch_evt,
   // alarm out
   output sle_pkg::sle_alarm_type            alarm_ff
);
   logic [`SLE_NUM_EV-1:0] pend_ff;
   logic [`SLE_NUM_EV-1:0] grant;
   logic [5:0]             sel;
   logic                   hit;

   function automatic logic [`SLE_CODE_W-1:0] code_of(input logic [5:0] idx);
      logic [5:0] off;
      off = idx - 6'h1b;
      if (idx >= 6'h1b) begin
         case (off[1:0])
            2'h0:    code_of = `SLE_FC_SHORTSUP;
            2'h1:    code_of = `SLE_FC_SHORTGND;
            2'h2:    code_of = `SLE_FC_CHACK;
            default: code_of = `SLE_FC_FREQHIGH;
         endcase
      end else begin
         case (idx)
            6'h00:   code_of = `SLE_FC_OVERTEMP;
            6'h01:   code_of = `SLE_FC_INTERNAL;
            6'h02:   code_of = `SLE_FC_PARAM;
            6'h03:   code_of = `SLE_FC_NOSUPPLY;
            6'h04:   code_of = `SLE_FC_SHUTOFF;
            6'h05:   code_of = `SLE_FC_FWINCONS;
            6'h06:   code_of = `SLE_FC_DSTMISM;
            6'h07:   code_of = `SLE_FC_DSTINV;
            6'h08:   code_of = `SLE_FC_SRCINV;
            6'h09:   code_of = `SLE_FC_WDZERO;
            6'h0a:   code_of = `SLE_FC_SILHIGH;
            6'h0b:   code_of = `SLE_FC_CRCLEN;
            6'h0c:   code_of = `SLE_FC_PARVER;
            6'h0d:   code_of = `SLE_FC_FIRSTCKS;
            6'h0e:   code_of = `SLE_FC_SAVETMO;
            6'h0f:   code_of = `SLE_FC_RESTTMO;
            6'h10:   code_of = `SLE_FC_INDCKS;
            6'h11:   code_of = `SLE_FC_BLOCKID;
            6'h12:   code_of = `SLE_FC_TXCRC;
            6'h13:   code_of = `SLE_FC_TXTMO;
            6'h14:   code_of = `SLE_FC_DEFECT;
            6'h15:   code_of = `SLE_FC_WDTRIP;
            6'h16:   code_of = `SLE_FC_FWINV;
            6'h17:   code_of = `SLE_FC_ADRMEM;
            6'h18:   code_of = `SLE_FC_UNDERTEMP;
            6'h19:   code_of = `SLE_FC_SUPHIGH;
            default: code_of = `SLE_FC_SUPLOW;
         endcase
      end
   endfunction : code_of

   // lowest pending index wins
   always_comb begin
      sel = 6'h0;
      hit = 1'b0;
      for (int i = `SLE_NUM_EV - 1; i >= 0; i--) begin
         if (pend_ff[i]) begin
            sel = 6'(i);
            hit = 1'b1;
         end
      end
      grant = hit ? ({{(`SLE_NUM_EV-1){1'b0}}, 1'b1} << sel) : '0;
   end

   // new events set, served one clears; set wins, no mask
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pend_ff <= '0;
      end else begin
         pend_ff <= (pend_ff & ~grant) | {ch_evt, mod_evt};
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         alarm_ff <= '0;
      end else begin
         alarm_ff.valid      <= hit;
         alarm_ff.code       <= code_of(sel);
         alarm_ff.chan_scope <= hit && (sel >= 6'h1b);
         alarm_ff.chan       <= (sel >= 6'h1b) ? 3'((sel - 6'h1b) >> 2) : 3'h0;
      end
   end

   chk_first_alarm_code : assert property (@(posedge clock) disable iff (!resetn)
      mod_evt[0] |-> ##2 (alarm_ff.valid && alarm_ff.code == `SLE_FC_OVERTEMP && !alarm_ff.chan_scope))
      else $error("overtemperature event not reported");
   chk_chan_scope : assert property (@(posedge clock) disable iff (!resetn)
      alarm_ff.valid && alarm_ff.chan_scope |-> alarm_ff.code inside
      {`SLE_FC_SHORTSUP, `SLE_FC_SHORTGND, `SLE_FC_CHACK, `SLE_FC_FREQHIGH})
      else $error("channel scope on a module code");
endmodule : sle_alarm_enc

/* verilog/sle_blink.sv */
// blink phase generator for all flashing indicators
// assumes one clock; phase toggles every HALF_CYCLES cycles
`timescale 1ns/1ps
`include "sle_cfg.svh"
module sle_blink #(
   parameter int unsigned HALF_CYCLES = `SLE_BLINK_CYCLES
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // phase
   output logic      phase_ff
);
   logic [31:0] cnt_ff;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_ff   <= 32'h0;
         phase_ff <= 1'b0;
      end else if (cnt_ff >= HALF_CYCLES - 1) begin
         cnt_ff   <= 32'h0;
         phase_ff <= ~phase_ff;
      end else begin
         cnt_ff <= cnt_ff + 32'h1;
      end
   end
endmodule : sle_blink

/* verilog/sle_cfg.svh */
// constants of the status led and alarm encoder block
// assumes a 100 MHz clock; included by package and modules
`ifndef SLE_CFG_SVH
`define SLE_CFG_SVH
`define SLE_NUM_CH        8
`define SLE_CODE_W        10
`define SLE_NUM_MEV       27
`define SLE_NUM_CEV       4
`define SLE_NUM_EV        59
`define SLE_CLK_KHZ       100000
`define SLE_BLINK_HALF_MS 500
`define SLE_BLINK_CYCLES  (`SLE_BLINK_HALF_MS * `SLE_CLK_KHZ)
`define SLE_FC_OVERTEMP   10'h005
`define SLE_FC_INTERNAL   10'h009
`define SLE_FC_PARAM      10'h010
`define SLE_FC_NOSUPPLY   10'h011
`define SLE_FC_SHUTOFF    10'h019
`define SLE_FC_FWINCONS   10'h01f
`define SLE_FC_DSTMISM    10'h040
`define SLE_FC_DSTINV     10'h041
`define SLE_FC_SRCINV     10'h042
`define SLE_FC_WDZERO     10'h043
`define SLE_FC_SILHIGH    10'h044
`define SLE_FC_CRCLEN     10'h045
`define SLE_FC_PARVER     10'h046
`define SLE_FC_FIRSTCKS   10'h047
`define SLE_FC_SAVETMO    10'h049
`define SLE_FC_RESTTMO    10'h04a
`define SLE_FC_INDCKS     10'h04b
`define SLE_FC_BLOCKID    10'h04c
`define SLE_FC_TXCRC      10'h04d
`define SLE_FC_TXTMO      10'h04e
`define SLE_FC_DEFECT     10'h100
`define SLE_FC_WDTRIP     10'h103
`define SLE_FC_FWINV      10'h11b
`define SLE_FC_ADRMEM     10'h30d
`define SLE_FC_UNDERTEMP  10'h312
`define SLE_FC_SUPHIGH    10'h321
`define SLE_FC_SUPLOW     10'h322
`define SLE_FC_SHORTSUP   10'h105
`define SLE_FC_SHORTGND   10'h106
`define SLE_FC_CHACK      10'h30b
`define SLE_FC_FREQHIGH   10'h311
`endif

/* verilog/sle_pkg.sv */
// types of the status led and alarm encoder block
// assumes sle_cfg.svh on the include path
`include "sle_cfg.svh"
package sle_pkg;
   typedef enum logic [2:0] {
      DIAG_DARK   = 3'h1,
      DIAG_FLASH  = 3'h2,
      DIAG_STEADY = 3'h4
   } sle_dmode_type;

   typedef struct packed {
      logic bus_ok;
      logic load_ok;
      logic params_set;
      logic mod_diag;
      logic mod_ack_wait;
      logic addr_mismatch;
      logic identify;
   } sle_mstate_type;

   typedef struct packed {
      logic [`SLE_NUM_CH-1:0] out;
      logic [`SLE_NUM_CH-1:0] diag;
      logic [`SLE_NUM_CH-1:0] ack_wait;
   } sle_chstate_type;

   typedef struct packed {
      logic                  valid;
      logic                  chan_scope;
      logic [2:0]            chan;
      logic [`SLE_CODE_W-1:0] code;
   } sle_alarm_type;
endpackage : sle_pkg

/* verilog/sle_status_led.sv */
// status indicators and diagnostic alarm output of an 8-channel output module
// assumes all inputs come from same-clock logic; event inputs are pulses
//
// How it works
// - diag led dark without backplane supply
// - diag led flashes while unparameterised
// - diag led steady when configured, no diagnostics
// - diag flashes on module diag or channel ack
// - diag flashes awaiting module error acknowledgment
// - channel leds follow output and diagnostics
// - ack-waiting channel flashes its leds alternately
// - address mismatch: status off, diag flash, faults on
// - identification: status and diag flash, faults off
// - supply led follows load supply
// - one alarm per diagnostic event, scoped
// - module codes 5, 9, 16, 17
// - module codes 25 and 31
// - module address codes 64, 65, 66
// - module codes 67 through 70
// - module codes 71, 73, 74, 75
// - module codes 76, 77, 78
// - module codes 256, 259, 283, 781
// - module codes 786, 801, 802
// - channel codes 261, 262, 779, 785
// - every alarm also flashes the diag led unless backplane supply is off
`timescale 1ns/1ps
`include "sle_cfg.svh"
module sle_status_led #(
   parameter int unsigned BLINK_CYCLES = `SLE_BLINK_CYCLES
) (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       resetn,
   // module and channel state
   input  sle_pkg::sle_mstate_type         mstate,
   input  sle_pkg::sle_chstate_type        chstate,
   // diagnostic events
   input  wire logic [`SLE_NUM_MEV-1:0]    mod_evt,
   input  wire logic [`SLE_NUM_CH*4-1:0]   ch_evt,
   input  wire logic                       diag_clear,
   // module indicators
   output logic                            diag_green_ff,
   output logic                            diag_red_ff,
   output logic                            load_supply_indicator_ff,
   // channel indicators
   output logic [`SLE_NUM_CH-1:0]          chan_status_ff,
   output logic [`SLE_NUM_CH-1:0]          chan_fault_ff,
   // alarm to the controller
   output sle_pkg::sle_alarm_type          alarm_ff
);
   logic                   phase_ff;
   logic                   evt_flash_ff;
   sle_pkg::sle_dmode_type mode_ff;
   sle_pkg::sle_dmode_type nxt_mode;
   logic                   any_ack;

   // shared blink phase
   sle_blink #(
      .HALF_CYCLES (BLINK_CYCLES)
   ) u_blink (
      .clock    (clock),
      .resetn   (resetn),
      .phase_ff (phase_ff)
   );

   // alarm encoder
   sle_alarm_enc u_enc (
      .clock    (clock),
      .resetn   (resetn),
      .mod_evt  (mod_evt),
      .ch_evt   (ch_evt),
      .alarm_ff (alarm_ff)
   );

   assign any_ack = |chstate.ack_wait;

   // event flash hold; a new alarm wins over clear
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         evt_flash_ff <= 1'b0;
      end else if (alarm_ff.valid) begin
         evt_flash_ff <= 1'b1;
      end else if (diag_clear) begin
         evt_flash_ff <= 1'b0;
      end
   end

   // diag led mode selection
   always_comb begin
      nxt_mode = sle_pkg::DIAG_STEADY;
      if (!mstate.bus_ok) begin
         nxt_mode = sle_pkg::DIAG_DARK;
      end else if (mstate.addr_mismatch || mstate.identify) begin
         nxt_mode = sle_pkg::DIAG_FLASH;
      end else if (!mstate.params_set) begin
         nxt_mode = sle_pkg::DIAG_FLASH;
      end else if (mstate.mod_diag || any_ack) begin
         nxt_mode = sle_pkg::DIAG_FLASH;
      end else if (mstate.mod_ack_wait) begin
         nxt_mode = sle_pkg::DIAG_FLASH;
      end else if (evt_flash_ff) begin
         nxt_mode = sle_pkg::DIAG_FLASH;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mode_ff <= sle_pkg::DIAG_DARK;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // diag led drive
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         diag_green_ff <= 1'b0;
         diag_red_ff   <= 1'b0;
      end else begin
         case (nxt_mode)
            sle_pkg::DIAG_DARK: begin
               diag_green_ff <= 1'b0;
               diag_red_ff   <= 1'b0;
            end
            sle_pkg::DIAG_FLASH: begin
               diag_green_ff <= 1'b0;
               diag_red_ff   <= phase_ff;
            end
            sle_pkg::DIAG_STEADY: begin
               diag_green_ff <= 1'b1;
               diag_red_ff   <= 1'b0;
            end
            default: begin
               diag_green_ff <= 1'b0;
               diag_red_ff   <= 1'b0;
            end
         endcase
      end
   end

   // supply led
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         load_supply_indicator_ff <= 1'b0;
      end else begin
         load_supply_indicator_ff <= mstate.load_ok;
      end
   end

   // channel leds
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         chan_status_ff <= '0;
         chan_fault_ff  <= '0;
      end else if (mstate.addr_mismatch) begin
         chan_status_ff <= '0;
         chan_fault_ff  <= '1;
      end else if (mstate.identify) begin
         chan_status_ff <= {`SLE_NUM_CH{phase_ff}};
         chan_fault_ff  <= '0;
      end else begin
         for (int i = 0; i < `SLE_NUM_CH; i++) begin
            if (chstate.ack_wait[i]) begin
               chan_status_ff[i] <= phase_ff;
               chan_fault_ff[i]  <= ~phase_ff;
            end else begin
               chan_status_ff[i] <= chstate.out[i] && !chstate.diag[i];
               chan_fault_ff[i]  <= chstate.diag[i];
            end
         end
      end
   end

   // checks
   chk_diag_dark_nobus : assert property (@(posedge clock) disable iff (!resetn)
      !mstate.bus_ok |=> !diag_green_ff && !diag_red_ff && mode_ff == sle_pkg::DIAG_DARK)
      else $error("diag led lit without backplane supply");

   chk_diag_unset_flash : assert property (@(posedge clock) disable iff (!resetn)
      mstate.bus_ok && !mstate.params_set |=> mode_ff == sle_pkg::DIAG_FLASH && !diag_green_ff
      && diag_red_ff == $past(phase_ff))
      else $error("diag led not flashing without parameters");

   chk_diag_steady_on : assert property (@(posedge clock) disable iff (!resetn)
      mstate.bus_ok && mstate.params_set && !mstate.mod_diag && !mstate.mod_ack_wait
      && !any_ack && !mstate.addr_mismatch && !mstate.identify && !evt_flash_ff
      |=> diag_green_ff && !diag_red_ff)
      else $error("diag led not steady when healthy");

   chk_diag_chan_ack : assert property (@(posedge clock) disable iff (!resetn)
      mstate.bus_ok && (mstate.mod_diag || any_ack) |=> !diag_green_ff
      && mode_ff == sle_pkg::DIAG_FLASH)
      else $error("diag led not flashing on diagnostics");

   chk_diag_mod_ack : assert property (@(posedge clock) disable iff (!resetn)
      mstate.bus_ok && mstate.mod_ack_wait |=> mode_ff == sle_pkg::DIAG_FLASH)
      else $error("diag led not flashing on module acknowledgment wait");

   chk_chan_plain_led : assert property (@(posedge clock) disable iff (!resetn)
      !mstate.addr_mismatch && !mstate.identify && !chstate.ack_wait[0]
      |=> chan_fault_ff[0] == $past(chstate.diag[0])
      && chan_status_ff[0] == ($past(chstate.out[0]) && !$past(chstate.diag[0])))
      else $error("channel leds disagree with output and diagnostics");

   chk_chan_antiphase : assert property (@(posedge clock) disable iff (!resetn)
      !mstate.addr_mismatch && !mstate.identify && chstate.ack_wait[0]
      |=> chan_status_ff[0] != chan_fault_ff[0] && chan_status_ff[0] == $past(phase_ff))
      else $error("channel leds not flashing in antiphase");

   chk_addr_mismatch : assert property (@(posedge clock) disable iff (!resetn)
      mstate.addr_mismatch |=> chan_status_ff == '0 && chan_fault_ff == '1
      && (!$past(mstate.bus_ok) || mode_ff == sle_pkg::DIAG_FLASH))
      else $error("mismatch display wrong");

   chk_identify_show : assert property (@(posedge clock) disable iff (!resetn)
      mstate.identify && !mstate.addr_mismatch |=> chan_fault_ff == '0
      && chan_status_ff == {`SLE_NUM_CH{$past(phase_ff)}}
      && (!$past(mstate.bus_ok) || diag_red_ff == $past(phase_ff)))
      else $error("identification display wrong");

   chk_supply_led : assert property (@(posedge clock) disable iff (!resetn)
      mstate.load_ok ##1 !mstate.load_ok |=> !load_supply_indicator_ff ##0 $past(load_supply_indicator_ff))
      else $error("supply led does not follow load supply");

   chk_alarm_flashes : assert property (@(posedge clock) disable iff (!resetn)
      alarm_ff.valid && !diag_clear ##1 (mstate.bus_ok && !diag_clear) |=> !diag_green_ff)
      else $error("alarm did not flash the diag led");

   // supply and diag colour
   chk_supply_on : assert property (@(posedge clock) disable iff (!resetn)
      mstate.load_ok |=> load_supply_indicator_ff)
      else $error("supply led dark with load supply");

   chk_supply_off : assert property (@(posedge clock) disable iff (!resetn)
      !mstate.load_ok |=> !load_supply_indicator_ff)
      else $error("supply led lit without load supply");

   chk_diag_one_colour : assert property (@(posedge clock) disable iff (!resetn)
      !(diag_green_ff && diag_red_ff))
      else $error("diag led shows both colours");

   chk_diag_flash_phase : assert property (@(posedge clock) disable iff (!resetn)
      nxt_mode == sle_pkg::DIAG_FLASH
      |=> !diag_green_ff && diag_red_ff == $past(phase_ff))
      else $error("diag flash off the blink phase");

   chk_mode_onehot : assert property (@(posedge clock) disable iff (!resetn)
      $onehot(mode_ff))
      else $error("diag mode not one-hot");

   chk_diag_dark_mode : assert property (@(posedge clock) disable iff (!resetn)
      nxt_mode == sle_pkg::DIAG_DARK
      |=> !diag_green_ff && !diag_red_ff)
      else $error("dark mode lights the diag led");

   chk_diag_steady_mode : assert property (@(posedge clock) disable iff (!resetn)
      nxt_mode == sle_pkg::DIAG_STEADY
      |=> diag_green_ff && !diag_red_ff)
      else $error("steady mode not green");

   // address and identification display
   chk_mismatch_flash : assert property (@(posedge clock) disable iff (!resetn)
      mstate.bus_ok && mstate.addr_mismatch
      |=> mode_ff == sle_pkg::DIAG_FLASH)
      else $error("mismatch does not flash diag");

   chk_identify_flash : assert property (@(posedge clock) disable iff (!resetn)
      mstate.bus_ok && mstate.identify
      |=> mode_ff == sle_pkg::DIAG_FLASH)
      else $error("identification does not flash diag");

   chk_mismatch_wins : assert property (@(posedge clock) disable iff (!resetn)
      mstate.addr_mismatch && mstate.identify |=> chan_status_ff == '0)
      else $error("identification shown over mismatch");

   // event flash hold and alarms
   chk_hold_set : assert property (@(posedge clock) disable iff (!resetn)
      alarm_ff.valid |=> evt_flash_ff)
      else $error("alarm did not arm the flash hold");

   chk_hold_clear : assert property (@(posedge clock) disable iff (!resetn)
      diag_clear && !alarm_ff.valid
      |=> !evt_flash_ff)
      else $error("flash hold not cleared");

   chk_hold_keeps : assert property (@(posedge clock) disable iff (!resetn)
      evt_flash_ff && !diag_clear |=> evt_flash_ff)
      else $error("flash hold dropped without clear");

   chk_hold_flashes : assert property (@(posedge clock) disable iff (!resetn)
      evt_flash_ff && mstate.bus_ok |=> mode_ff == sle_pkg::DIAG_FLASH)
      else $error("flash hold does not flash diag");

   chk_alarm_follows : assert property (@(posedge clock) disable iff (!resetn)
      (|mod_evt) || (|ch_evt)
      |-> ##2 alarm_ff.valid)
      else $error("event raised no alarm");

   chk_module_chan_zero : assert property (@(posedge clock) disable iff (!resetn)
      alarm_ff.valid && !alarm_ff.chan_scope |-> alarm_ff.chan == 3'h0)
      else $error("module alarm carries a channel");

   // per-channel display checks
   for (genvar g = 0; g < `SLE_NUM_CH; g++) begin : g_chan_chk
      chk_chan_fault_led : assert property (@(posedge clock) disable iff (!resetn)
         !mstate.addr_mismatch && !mstate.identify && !chstate.ack_wait[g]
         |=> chan_fault_ff[g] == $past(chstate.diag[g]))
         else $error("channel fault led disagrees with diagnostics");

      chk_chan_status_led : assert property (@(posedge clock) disable iff (!resetn)
         !mstate.addr_mismatch && !mstate.identify && !chstate.ack_wait[g]
         |=> chan_status_ff[g] == ($past(chstate.out[g]) && !$past(chstate.diag[g])))
         else $error("channel status led disagrees with output");

      chk_chan_alternate : assert property (@(posedge clock) disable iff (!resetn)
         !mstate.addr_mismatch && !mstate.identify && chstate.ack_wait[g]
         |=> chan_status_ff[g] == $past(phase_ff) && chan_fault_ff[g] == !$past(phase_ff))
         else $error("channel leds not alternating");

      chk_chan_ack_flash : assert property (@(posedge clock) disable iff (!resetn)
         mstate.bus_ok && chstate.ack_wait[g]
         |=> mode_ff == sle_pkg::DIAG_FLASH)
         else $error("channel acknowledgment wait does not flash diag");
   end : g_chan_chk

   // helper: cycles since the last blink toggle
   logic        phase_seen_ff;
   logic [31:0] since_ff;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         phase_seen_ff <= 1'b0;
         since_ff      <= 32'h0;
      end else begin
         phase_seen_ff <= phase_ff;
         if (phase_ff != phase_seen_ff) begin
            since_ff <= 32'h1;
         end else begin
            since_ff <= since_ff + 32'h1;
         end
      end
   end

   chk_blink_early : assert property (@(posedge clock) disable iff (!resetn)
      phase_ff != phase_seen_ff |-> since_ff == BLINK_CYCLES)
      else $error("blink phase toggled off period");

   chk_blink_stuck : assert property (@(posedge clock) disable iff (!resetn)
      since_ff <= BLINK_CYCLES)
      else $error("blink phase stuck");
endmodule : sle_status_led
